// [hw/acstp_target_port.v]
// Two-wire serial target port of a three-axis acceleration sensor
//
// Overview of operation
// - Falling data while clock high is start
// - First byte: address bits, then direction bit
// - Selected only when address bits match ours
// - Address is fixed pattern plus strap bit
// - Transmitter releases data, receiver holds low
// - Addressed receiver acknowledges every complete byte
// - Rising data while clock high is stop
// - Write: address, pointer, data, each acknowledged
// - Pointer advances after each written data byte
// - Read: pointer write, repeated start, read address
// - Pointer advances after each read byte
// - Not-ready receiver may hold clock low
// - Hold clock during conversion if stretch bit
// - Axis read: pointer zero, hold, six bytes
// - Four-wire side is target only
// - Data output released while not selected
// - Bytes are eight bits, most significant first
// - Eleven registers: outputs, reset, two controls
`timescale 1ns/1ns
`include "acstp_map.vh"
module acstp_target_port #(
    parameter [31:0] CONV_HOLD_CYC =
        (`ACSTP_CONV_HOLD_NS + `ACSTP_CLK_PERIOD_NS - 1) / `ACSTP_CLK_PERIOD_NS
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire scl_in,
    input wire sda_in,
    input wire device_select_low_in,
    input wire addr_sel_in,
    input wire [11:0] x_accel_in,
    input wire [11:0] y_accel_in,
    input wire [11:0] z_accel_in,
    input wire [11:0] aux_in,
    input wire conv_done_in,
    output wire sda_out,
    output wire sda_oe_out,
    output wire scl_out,
    output wire scl_oe_out,
    output wire bus_busy_out,
    output wire conv_start_out,
    output wire soft_reset_out,
    output wire [7:0] mode_control_first_out,
    output wire [7:0] mode_control_second_out
);

////////////////////////////////////////////////////////////////////////////////
// States and byte kinds

localparam [6:0] ST_IDLE = 7'h01;
localparam [6:0] ST_RX = 7'h02;
localparam [6:0] ST_RX_ACK = 7'h04;
localparam [6:0] ST_HOLD = 7'h08;
localparam [6:0] ST_TX = 7'h10;
localparam [6:0] ST_TX_ACK = 7'h20;
localparam [6:0] ST_IGNORE = 7'h40;

localparam [1:0] KIND_ADDR = 2'h0;
localparam [1:0] KIND_PTR = 2'h1;
localparam [1:0] KIND_DATA = 2'h2;

localparam [14:0] HOLD_LOAD = CONV_HOLD_CYC[14:0];

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

wire scl_f;
wire sda_f;
wire sel_f;
wire addr_f;

acstp_sync #(.RST_VAL(1'b1)) u_sync_scl (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(scl_in),
    .level_out(scl_f)
);

acstp_sync #(.RST_VAL(1'b1)) u_sync_sda (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(sda_in),
    .level_out(sda_f)
);

acstp_sync #(.RST_VAL(1'b1)) u_sync_sel (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(device_select_low_in),
    .level_out(sel_f)
);

// Strap is caught after release through the clocked synchroniser
acstp_sync #(.RST_VAL(1'b0)) u_sync_addr (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(addr_sel_in),
    .level_out(addr_f)
);

////////////////////////////////////////////////////////////////////////////////
// Edge and condition detection

reg scl_q_ff;
reg sda_q_ff;

always @(posedge clk_in) begin
    if (sys_rst_in) begin
        scl_q_ff <= 1'b1;
        sda_q_ff <= 1'b1;
    end else begin
        scl_q_ff <= scl_f;
        sda_q_ff <= sda_f;
    end
end

wire i2c_mode = sel_f;
wire spi_sel = ~sel_f;
wire scl_rise = scl_f & ~scl_q_ff;
wire scl_fall = ~scl_f & scl_q_ff;
wire start_det = i2c_mode & scl_f & scl_q_ff & sda_q_ff & ~sda_f;
wire stop_det = i2c_mode & scl_f & scl_q_ff & ~sda_q_ff & sda_f;

////////////////////////////////////////////////////////////////////////////////
// Register storage

reg [7:0] axis_ff [0:7];
reg [7:0] mode_first_ff;
reg [7:0] mode_second_ff;
reg [7:0] ptr_ff;
reg [7:0] rd_byte;

// Unmapped pointers read as zero
always @* begin
    rd_byte = 8'h00;
    if (ptr_ff <= `ACSTP_PTR_AXIS_LAST) begin
        rd_byte = axis_ff[ptr_ff[2:0]];
    end else if (ptr_ff == `ACSTP_PTR_MODE_FIRST) begin
        rd_byte = mode_first_ff;
    end else if (ptr_ff == `ACSTP_PTR_MODE_SECOND) begin
        rd_byte = mode_second_ff;
    end
end

// Result split into high byte and low nibble padded with zeros
always @(posedge clk_in) begin
    if (sys_rst_in) begin
        axis_ff[0] <= 8'h00;
        axis_ff[1] <= 8'h00;
        axis_ff[2] <= 8'h00;
        axis_ff[3] <= 8'h00;
        axis_ff[4] <= 8'h00;
        axis_ff[5] <= 8'h00;
        axis_ff[6] <= 8'h00;
        axis_ff[7] <= 8'h00;
    end else if (conv_done_in) begin
        axis_ff[0] <= x_accel_in[11:4];
        axis_ff[1] <= {x_accel_in[3:0], 4'h0};
        axis_ff[2] <= y_accel_in[11:4];
        axis_ff[3] <= {y_accel_in[3:0], 4'h0};
        axis_ff[4] <= z_accel_in[11:4];
        axis_ff[5] <= {z_accel_in[3:0], 4'h0};
        axis_ff[6] <= aux_in[11:4];
        axis_ff[7] <= {aux_in[3:0], 4'h0};
    end
end

////////////////////////////////////////////////////////////////////////////////
// Protocol engine

reg [6:0] state_ff;
reg [6:0] nxt_state;
reg [1:0] kind_ff;
reg [1:0] nxt_kind;
reg [2:0] cnt_ff;
reg [2:0] nxt_cnt;
reg [7:0] shift_ff;
reg [7:0] nxt_shift;
reg [7:0] tx_ff;
reg [7:0] nxt_tx;
reg [7:0] nxt_ptr;
reg full_ff;
reg nxt_full;
reg rw_ff;
reg nxt_rw;
reg drive_ff;
reg nxt_drive;
reg hold_ff;
reg nxt_hold;
reg busy_ff;
reg nxt_busy;
reg mack_ff;
reg nxt_mack;
reg wr_en;
reg conv_start;
reg [14:0] hold_cnt_ff;
reg conv_seen_ff;
reg sda_oe_ff;
reg sda_o_ff;
reg conv_start_ff;
reg soft_reset_ff;

wire addr_match = (shift_ff[7:1] == {`ACSTP_ADDR_FIXED, addr_f});
wire stretch_en = mode_second_ff[`ACSTP_CLK_STRETCH_BIT];

always @* begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_tx = tx_ff;
    nxt_ptr = ptr_ff;
    nxt_full = full_ff;
    nxt_rw = rw_ff;
    nxt_drive = drive_ff;
    nxt_hold = hold_ff;
    nxt_busy = busy_ff;
    nxt_mack = mack_ff;
    wr_en = 1'b0;
    conv_start = 1'b0;
    if (!i2c_mode) begin
        nxt_state = ST_IDLE;
        nxt_drive = 1'b0;
        nxt_hold = 1'b0;
        nxt_busy = 1'b0;
    end else if (start_det) begin
        // Repeated start keeps the pointer for the following read
        nxt_state = ST_RX;
        nxt_kind = KIND_ADDR;
        nxt_cnt = 3'h0;
        nxt_full = 1'b0;
        nxt_drive = 1'b0;
        nxt_hold = 1'b0;
        nxt_busy = 1'b1;
    end else if (stop_det) begin
        nxt_state = ST_IDLE;
        nxt_drive = 1'b0;
        nxt_hold = 1'b0;
        nxt_busy = 1'b0;
    end else begin
        case (state_ff)
            ST_RX: begin
                if (scl_rise) begin
                    nxt_shift = {shift_ff[6:0], sda_f};
                    nxt_cnt = cnt_ff + 3'h1;
                    if (cnt_ff == 3'h7) begin
                        nxt_full = 1'b1;
                    end
                end else if (scl_fall && full_ff) begin
                    nxt_full = 1'b0;
                    if (kind_ff != KIND_ADDR) begin
                        nxt_state = ST_RX_ACK;
                        nxt_drive = 1'b1;
                    end else if (addr_match) begin
                        nxt_state = ST_RX_ACK;
                        nxt_drive = 1'b1;
                        nxt_rw = shift_ff[`ACSTP_RW_BIT];
                    end else begin
                        nxt_state = ST_IGNORE;
                    end
                end
            end
            ST_RX_ACK: begin
                if (scl_fall) begin
                    nxt_drive = 1'b0;
                    nxt_cnt = 3'h0;
                    if (kind_ff == KIND_ADDR && rw_ff) begin
                        nxt_state = ST_TX;
                        nxt_tx = rd_byte;
                        nxt_drive = ~rd_byte[7];
                    end else if (kind_ff == KIND_ADDR) begin
                        nxt_state = ST_RX;
                        nxt_kind = KIND_PTR;
                    end else if (kind_ff == KIND_PTR) begin
                        nxt_ptr = shift_ff;
                        nxt_state = ST_RX;
                        nxt_kind = KIND_DATA;
                        if (shift_ff <= `ACSTP_PTR_AXIS_LAST) begin
                            conv_start = 1'b1;
                            if (stretch_en) begin
                                nxt_state = ST_HOLD;
                                nxt_hold = 1'b1;
                            end
                        end
                    end else begin
                        wr_en = 1'b1;
                        nxt_ptr = ptr_ff + 8'h01;
                        nxt_state = ST_RX;
                    end
                end
            end
            ST_HOLD: begin
                // Clock stays low until both the minimum time and the result
                if (hold_cnt_ff == 15'h0000 && conv_seen_ff) begin
                    nxt_hold = 1'b0;
                    nxt_state = ST_RX;
                end
            end
            ST_TX: begin
                if (scl_fall) begin
                    if (cnt_ff == 3'h7) begin
                        nxt_drive = 1'b0;
                        nxt_state = ST_TX_ACK;
                        nxt_cnt = 3'h0;
                        nxt_mack = 1'b0;
                    end else begin
                        nxt_tx = {tx_ff[6:0], 1'b0};
                        nxt_cnt = cnt_ff + 3'h1;
                        nxt_drive = ~tx_ff[6];
                    end
                end
            end
            ST_TX_ACK: begin
                if (scl_rise) begin
                    nxt_ptr = ptr_ff + 8'h01;
                    nxt_mack = ~sda_f;
                    if (sda_f) begin
                        // Not-acknowledge ends the read burst
                        nxt_state = ST_IGNORE;
                    end
                end else if (scl_fall && mack_ff) begin
                    nxt_mack = 1'b0;
                    nxt_state = ST_TX;
                    nxt_tx = rd_byte;
                    nxt_drive = ~rd_byte[7];
                end
            end
            ST_IDLE: begin
                nxt_drive = 1'b0;
            end
            ST_IGNORE: begin
                nxt_drive = 1'b0;
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_drive = 1'b0;
                nxt_hold = 1'b0;
            end
        endcase
    end
end

always @(posedge clk_in) begin
    if (sys_rst_in) begin
        state_ff <= ST_IDLE;
        kind_ff <= KIND_ADDR;
        cnt_ff <= 3'h0;
        shift_ff <= 8'h00;
        tx_ff <= 8'h00;
        ptr_ff <= 8'h00;
        full_ff <= 1'b0;
        rw_ff <= 1'b0;
        drive_ff <= 1'b0;
        hold_ff <= 1'b0;
        busy_ff <= 1'b0;
        mack_ff <= 1'b0;
    end else begin
        state_ff <= nxt_state;
        kind_ff <= nxt_kind;
        cnt_ff <= nxt_cnt;
        shift_ff <= nxt_shift;
        tx_ff <= nxt_tx;
        ptr_ff <= nxt_ptr;
        full_ff <= nxt_full;
        rw_ff <= nxt_rw;
        drive_ff <= nxt_drive;
        hold_ff <= nxt_hold;
        busy_ff <= nxt_busy;
        mack_ff <= nxt_mack;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Conversion hold timing and control register writes

// A result arriving in the start cycle is kept: set wins over clear
always @(posedge clk_in) begin
    if (sys_rst_in) begin
        hold_cnt_ff <= 15'h0000;
        conv_seen_ff <= 1'b0;
    end else begin
        if (conv_start) begin
            hold_cnt_ff <= HOLD_LOAD;
        end else if (hold_cnt_ff != 15'h0000) begin
            hold_cnt_ff <= hold_cnt_ff - 15'h0001;
        end
        if (conv_done_in) begin
            conv_seen_ff <= 1'b1;
        end else if (conv_start) begin
            conv_seen_ff <= 1'b0;
        end
    end
end

// Only the two control registers take data; output bytes are read-only
always @(posedge clk_in) begin
    if (sys_rst_in) begin
        mode_first_ff <= `ACSTP_MODE_FIRST_RST;
        mode_second_ff <= `ACSTP_MODE_SECOND_RST;
        soft_reset_ff <= 1'b0;
        conv_start_ff <= 1'b0;
    end else begin
        if (wr_en && ptr_ff == `ACSTP_PTR_MODE_FIRST) begin
            mode_first_ff <= shift_ff;
        end
        if (wr_en && ptr_ff == `ACSTP_PTR_MODE_SECOND) begin
            mode_second_ff <= shift_ff;
        end
        soft_reset_ff <= wr_en && (ptr_ff == `ACSTP_PTR_SOFT_RESET);
        conv_start_ff <= conv_start;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin drivers

// Four-wire side never drives the clock; its framing is not built here
always @(posedge clk_in) begin
    if (sys_rst_in) begin
        sda_oe_ff <= 1'b0;
        sda_o_ff <= 1'b0;
    end else begin
        sda_oe_ff <= i2c_mode ? nxt_drive : spi_sel;
        sda_o_ff <= i2c_mode ? 1'b0 : rd_byte[7];
    end
end

assign sda_out = sda_o_ff;
assign sda_oe_out = sda_oe_ff;
assign scl_out = 1'b0;
assign scl_oe_out = hold_ff;
assign bus_busy_out = busy_ff;
assign conv_start_out = conv_start_ff;
assign soft_reset_out = soft_reset_ff;
assign mode_control_first_out = mode_first_ff;
assign mode_control_second_out = mode_second_ff;

endmodule

// [hw/acstp_map.vh]
// Constants of the acceleration sensor serial target port
`ifndef ACSTP_MAP_VH
`define ACSTP_MAP_VH

// Fixed upper six bits of the seven-bit target bus address
`define ACSTP_ADDR_FIXED 6'h0C
// Direction bit inside the address byte, 1 = controller reads
`define ACSTP_RW_BIT 0

// Register pointer values
`define ACSTP_PTR_X_HIGH 8'h00
`define ACSTP_PTR_X_LOW 8'h01
`define ACSTP_PTR_Y_HIGH 8'h02
`define ACSTP_PTR_Y_LOW 8'h03
`define ACSTP_PTR_Z_HIGH 8'h04
`define ACSTP_PTR_Z_LOW 8'h05
`define ACSTP_PTR_AUX_HIGH 8'h06
`define ACSTP_PTR_AUX_LOW 8'h07
`define ACSTP_PTR_AXIS_LAST 8'h07
`define ACSTP_PTR_SOFT_RESET 8'h0A
`define ACSTP_PTR_MODE_FIRST 8'h0C
`define ACSTP_PTR_MODE_SECOND 8'h0D

// Reset values of the control registers
`define ACSTP_MODE_FIRST_RST 8'h00
`define ACSTP_MODE_SECOND_RST 8'h00

// Position of the conversion clock stretch bit in mode_control_second
`define ACSTP_CLK_STRETCH_BIT 6

// Timing
`define ACSTP_CLK_PERIOD_NS 32'h0000_0008
`define ACSTP_CONV_HOLD_NS 32'h0003_0D40

`endif

// [hw/acstp_sync.v]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module acstp_sync #(
    parameter RST_VAL = 1'b1
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire async_in,
    output wire level_out
);

reg stage1_ff;
reg stage2_ff;
reg stage3_ff;
reg level_ff;

// Output moves only when the second and third stages agree
always @(posedge clk_in) begin
    if (sys_rst_in) begin
        stage1_ff <= RST_VAL;
        stage2_ff <= RST_VAL;
        stage3_ff <= RST_VAL;
        level_ff <= RST_VAL;
    end else begin
        stage1_ff <= async_in;
        stage2_ff <= stage1_ff;
        stage3_ff <= stage2_ff;
        if (stage2_ff == stage3_ff) begin
            level_ff <= stage3_ff;
        end
    end
end

assign level_out = level_ff;

endmodule

// [verif/acstp_target_port_checker.sv]
// Concurrent checks on the ports of the two-wire serial target port
`timescale 1ns/1ns
module acstp_checker #(
    parameter [31:0] CONV_HOLD_CYC = 32'h0000_61A8
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire scl_in,
    input wire sda_in,
    input wire device_select_low_in,
    input wire sda_out,
    input wire sda_oe_out,
    input wire scl_out,
    input wire scl_oe_out,
    input wire bus_busy_out,
    input wire conv_start_out,
    input wire soft_reset_out,
    input wire [7:0] mode_control_second_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////
    // Length of the current clock hold, in system cycles
    reg [31:0] hold_cnt_ff;
    wire [31:0] nxt_hold_cnt = scl_oe_out ? hold_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            hold_cnt_ff <= 32'h0000_0000;
        end else begin
            hold_cnt_ff <= nxt_hold_cnt;
        end
    end
    ////////////////////////////////////////
    sequence start_seq;
        device_select_low_in && scl_in && $fell(sda_in);
    endsequence
    sequence stop_seq;
        device_select_low_in && scl_in && $rose(sda_in);
    endsequence
    // Mode pin must have settled, else the four-wire drive switch looks like a bit change
    sequence high_phase_seq;
        (scl_in && device_select_low_in && $past(device_select_low_in, 8))[*5];
    endsequence
    ////////////////////////////////////////
    a_busy_on_start: assert property (start_seq |-> ##[1:12] bus_busy_out)
        else $error("bus not busy after start");
    a_free_on_stop: assert property (stop_seq |-> ##[1:12] !bus_busy_out)
        else $error("bus still busy after stop");
    a_data_stable_high: assert property (high_phase_seq |-> $stable(sda_oe_out))
        else $error("data drive changed while clock high");
    a_sda_pull_only: assert property (device_select_low_in[*8] |-> !sda_out)
        else $error("data driven high in two-wire mode");
    a_four_wire_drive: assert property ((!device_select_low_in)[*8] |-> sda_oe_out)
        else $error("data not driven while selected");
    a_stretch_needs_bit: assert property ($rose(scl_oe_out) |-> mode_control_second_out[6])
        else $error("clock held without stretch bit");
    a_stretch_min_len: assert property ($fell(scl_oe_out) |-> hold_cnt_ff >= CONV_HOLD_CYC - 2)
        else $error("clock hold too short");
    a_conv_pulse_once: assert property (conv_start_out |=> !conv_start_out)
        else $error("conversion start longer than one cycle");
    a_reset_pulse_once: assert property (soft_reset_out |=> !soft_reset_out)
        else $error("soft reset longer than one cycle");
    a_scl_pull_only: assert property (!scl_out)
        else $error("clock driven high");
endmodule

bind acstp_target_port acstp_checker #(.CONV_HOLD_CYC(CONV_HOLD_CYC)) chk_i (
    .clk_in,
    .sys_rst_in,
    .scl_in,
    .sda_in,
    .device_select_low_in,
    .sda_out,
    .sda_oe_out,
    .scl_out,
    .scl_oe_out,
    .bus_busy_out,
    .conv_start_out,
    .soft_reset_out,
    .mode_control_second_out
);

// [verif/acstp_bus_ctl.sv]
// Bus controller model driving the two-wire clock and data lines
`timescale 1ns/1ns
module acstp_bus_ctl (
    input wire scl_in,
    input wire sda_in,
    output logic scl_drv_out,
    output logic sda_drv_out
);
    initial begin
        scl_drv_out = 1'b1;
        sda_drv_out = 1'b1;
    end
    ////////////////////////////////////////
    // A target may hold the clock low; wait for it, but not forever
    task automatic wait_hi();
        for (int i = 0; i < 100000 && !scl_in; i++) #1;
    endtask
    task automatic clk_bit(input logic b, output logic r);
        #31 sda_drv_out = b;
        #31 scl_drv_out = 1'b1;
        wait_hi();
        #31 r = sda_in;
        #32 scl_drv_out = 1'b0;
    endtask
    task automatic start();
        if (!scl_drv_out) begin
            #31 sda_drv_out = 1'b1;
            #31 scl_drv_out = 1'b1;
            wait_hi();
        end
        #31 sda_drv_out = 1'b0;
        #32 scl_drv_out = 1'b0;
    endtask
    task automatic stop();
        #31 sda_drv_out = 1'b0;
        #31 scl_drv_out = 1'b1;
        wait_hi();
        #31 sda_drv_out = 1'b1;
        #32;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
        clk_bit(1'b1, ack);
    endtask
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, r);
            b[i] = r;
        end
        clk_bit(last, r);
    endtask
endmodule

// [verif/acstp_target_port_tb.sv]
// Self-checking testbench for the two-wire serial target port
`timescale 1ns/1ns
module acstp_target_port_tb;
    localparam int HOLD = 20;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic sel_low = 1'b1;
    logic addr_sel = 1'b0;
    logic conv_done = 1'b0;
    logic [11:0] acc [4] = '{12'h000, 12'h000, 12'h000, 12'h000};
    logic scl_drv, sda_drv, sda_o, sda_oe, scl_o, scl_oe, busy, conv_start, soft_rst, ack;
    logic [7:0] mode1, mode2, rb;
    wire scl_w = scl_drv & (~scl_oe | scl_o);
    wire sda_w = sda_drv & (~sda_oe | sda_o);
    int n_mismatch = 0;
    int comparisons = 0;
    int n_conv = 0, n_soft = 0, n_hold = 0;
    int regs [16];
    acstp_target_port #(.CONV_HOLD_CYC(HOLD)) dut (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .scl_in(scl_w),
        .sda_in(sda_w),
        .device_select_low_in(sel_low),
        .addr_sel_in(addr_sel),
        .x_accel_in(acc[0]),
        .y_accel_in(acc[1]),
        .z_accel_in(acc[2]),
        .aux_in(acc[3]),
        .conv_done_in(conv_done),
        .sda_out(sda_o),
        .sda_oe_out(sda_oe),
        .scl_out(scl_o),
        .scl_oe_out(scl_oe),
        .bus_busy_out(busy),
        .conv_start_out(conv_start),
        .soft_reset_out(soft_rst),
        .mode_control_first_out(mode1),
        .mode_control_second_out(mode2)
    );
    acstp_bus_ctl ctl (
        .scl_in(scl_w),
        .sda_in(sda_w),
        .scl_drv_out(scl_drv),
        .sda_drv_out(sda_drv)
    );
    always #4 clk_in = ~clk_in;
    ////////////////////////////////////////
    // Conversion finishes one cycle after it is started
    always @(posedge clk_in) begin
        if (conv_start === 1'b1) n_conv++;
        if (soft_rst === 1'b1) n_soft++;
        if (scl_oe === 1'b1) n_hold++;
        conv_done <= (conv_start === 1'b1);
    end
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic send(logic [7:0] ab, logic exp_ack);
        ctl.start();
        ctl.wbyte(ab, ack);
        chk("address ack", ack, exp_ack);
    endtask
    task automatic put(logic [7:0] b);
        ctl.wbyte(b, ack);
        chk("byte ack", ack, 0);
    endtask
    task automatic get(int n, int p);
        for (int i = 0; i < n; i++) begin
            ctl.rbyte(i == n - 1, rb);
            chk("read byte", rb, regs[(p + i) % 16]);
        end
    endtask
    task automatic pstop();
        ctl.stop();
        repeat (12) @(posedge clk_in);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #600_000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h12b7));
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        chk("mode first", mode1, 8'h00);
        chk("mode second", mode2, 8'h00);
        $display("done: reset");
        // Mode set-up write of two consecutive registers
        regs[12] = $urandom & 32'h0000_00ff;
        regs[13] = ($urandom & 32'h0000_00ff) | 32'h0000_0040;
        send(8'h30, 1'b0);
        chk("busy after start", busy, 1);
        put(8'h0c);
        put(regs[12][7:0]);
        put(regs[13][7:0]);
        pstop();
        chk("busy after stop", busy, 0);
        chk("mode first", mode1, regs[12]);
        chk("mode second", mode2, regs[13]);
        send(8'h30, 1'b0);
        put(8'h0c);
        send(8'h31, 1'b0);
        get(2, 12);
        pstop();
        $display("done: write and read");
        // Each address one bit away from ours must be ignored, including its payload
        for (int k = 1; k < 8; k++) begin
            send(8'h30 ^ (8'h01 << k), 1'b1);
            ctl.wbyte(8'h0c, ack);
            chk("ignored ack", ack, 1);
            pstop();
        end
        chk("mode kept", mode1, regs[12]);
        send(8'h30, 1'b0);
        put(8'h0a);
        put(8'h00);
        pstop();
        chk("soft reset", n_soft, 1);
        $display("done: address and soft reset");
        @(posedge clk_in);
        for (int i = 0; i < 4; i++) acc[i] <= 12'($urandom);
        @(posedge clk_in);
        for (int i = 0; i < 4; i++) begin
            regs[2 * i] = acc[i][11:4];
            regs[2 * i + 1] = {acc[i][3:0], 4'h0};
        end
        send(8'h30, 1'b0);
        put(8'h00);
        send(8'h31, 1'b0);
        get(6, 0);
        pstop();
        chk("conversions", n_conv, 1);
        chk("stretched", n_hold >= HOLD, 1);
        send(8'h31, 1'b0);
        get(2, 6);
        pstop();
        send(8'h30, 1'b0);
        put(8'h0d);
        put(8'h00);
        pstop();
        n_hold = 0;
        send(8'h30, 1'b0);
        put(8'h00);
        pstop();
        chk("no stretch", n_hold, 0);
        $display("done: axis read");
        sys_rst_in <= 1'b1;
        addr_sel <= 1'b1;
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        chk("mode after reset", mode1, 8'h00);
        send(8'h30, 1'b1);
        pstop();
        send(8'h32, 1'b0);
        put(8'h0c);
        put(8'h81);
        pstop();
        chk("strap write", mode1, 8'h81);
        $display("done: strap");
        sel_low <= 1'b0;
        repeat (10) @(posedge clk_in);
        chk("selected drive", sda_oe, 1);
        sel_low <= 1'b1;
        repeat (10) @(posedge clk_in);
        chk("released", sda_oe, 0);
        $display("done: four-wire");
        report_and_stop();
    end
endmodule
